// file: rtl/cca_pkg.sv
package cca_pkg;
   localparam int         NMOD    = 6;
   localparam logic [7:0] A_CTRL  = 8'hD8;
   localparam logic [7:0] A_MODE  = 8'hD9;
   localparam logic [7:0] A_MM0   = 8'hDA;
   localparam logic [7:0] A_CNTL  = 8'hE9;
   localparam logic [7:0] A_CNTH  = 8'hF9;
   localparam logic [7:0] A_RLDL  = 8'hCE;
   localparam logic [7:0] A_RLDH  = 8'hCF;
   localparam logic [7:0] A_CAPL0 = 8'hEA;
   localparam logic [7:0] A_CAPH0 = 8'hFA;
   localparam logic [7:0] A_AUX0  = 8'hF2;
   localparam int B_OVF  = 7;
   localparam int B_RUN  = 6;
   localparam int B_BUFFER_PAIR01_ENABLE = 4;
   localparam int B_CPS  = 1;
   localparam int B_ECF  = 0;
   localparam int M_DTE  = 7;
   localparam int M_ECOM = 6;
   localparam int M_CAPP = 5;
   localparam int M_CAPN = 4;
   localparam int M_MAT  = 3;
   localparam int M_TOG  = 2;
   localparam int M_PWM  = 1;
   localparam int M_ECCF = 0;
   localparam int X_RES  = 6;
   localparam int X_PH   = 3;
   localparam int X_INV  = 2;
   localparam int X_EXH  = 1;
   localparam logic [2:0] CK_DIV12 = 3'h0;
   localparam logic [2:0] CK_DIV2  = 3'h1;
   localparam logic [2:0] CK_TMR0  = 3'h2;
   localparam logic [2:0] CK_EXT   = 3'h3;
   localparam logic [2:0] CK_X16   = 3'h4;
   localparam logic [2:0] CK_DIV1  = 3'h5;
   localparam logic [2:0] CK_BAUD  = 3'h6;
   localparam logic [2:0] CK_MCK   = 3'h7;
   localparam int         PRE_DIV  = 12;
   localparam logic [3:0] PRE_LAST = 4'(PRE_DIV - 1);
   localparam logic [15:0] CNT_TOP = 16'hFFFF;
   localparam logic [7:0][15:0] PHASE_PT = {16'hD555, 16'h2AAA, 16'hAAAA,
      16'h5555, 16'hC000, 16'h8000, 16'h4000, 16'h0000};
   typedef struct packed {
      logic [7:0] addr;
      logic       page;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } sfr_req_t;
   typedef struct packed {
      logic tmr0_ovf;
      logic ext_clk;
      logic x16_tick;
      logic baud_ovf;
      logic mck_tick;
   } tick_src_t;
   typedef struct packed {
      logic                   ovf;
      logic                   run;
      logic [NMOD-1:0]        ev;
      logic [7:0]             counter_mode_register;
      logic [15:0]            cnt;
      logic [15:0]            rld;
      logic [NMOD-1:0][7:0]   mm;
      logic [NMOD-1:0][7:0]   cap_l;
      logic [NMOD-1:0][7:0]   cap_h;
      logic [NMOD-1:0][7:0]   aux;
      logic [NMOD-1:0][16:0]  act;
      logic [NMOD-1:0]        pin;
      logic [NMOD-1:0]        oe;
      logic [NMOD-1:0]        s1;
      logic [NMOD-1:0]        s2;
      logic [NMOD-1:0]        s3;
      logic                   e1;
      logic                   e2;
      logic                   e3;
      logic [3:0]             pre;
      logic                   half;
      logic                   moved;
      logic [2:0]             bsel;
      logic                   irq;
   } array_state_t;
   typedef struct packed {
      logic [7:0] rdata;
   } top_state_t;
endpackage

// file: rtl/counter_array_capture_compare_pwm.sv
`timescale 1ns/1ps

module counter_array #(
   parameter bit HAS_DEADTIME = 1'b1
) (
   input  wire logic                core_clk,
   input  wire logic                srst,
   input  wire cca_pkg::sfr_req_t   req,
   input  wire logic                sel,
   input  wire cca_pkg::tick_src_t  ticks,
   input  wire logic [5:0]          pin_in,
   output logic [7:0]               rdata,
   output logic [5:0]               pin_out,
   output logic [5:0]               pin_oe,
   output logic                     irq
);
   cca_pkg::array_state_t s;
   cca_pkg::array_state_t next_s;
   logic        wr_here;
   logic        tick;
   logic        adv;
   logic [5:0]  capm;
   logic [5:0]  tmrm;
   logic [5:0]  pwmm;
   logic [5:0]  edge_ok;
   logic [5:0]  cap_hit;
   logic [5:0]  match;
   logic [5:0]  pwm_lvl;
   logic [2:0]  bufc;
   logic [2:0]  bufp;
   logic [15:0] mask;
   logic [15:0] ph;
   logic [16:0] wbit;
   logic [16:0] src;
   logic [16:0] cval;
   logic        low;

   assign wr_here = req.wr & sel;
   assign pin_out = s.pin;
   assign pin_oe  = s.oe;
   assign irq     = s.irq;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_s  = s;
      tick    = 1'b0;
      capm    = '0;
      tmrm    = '0;
      pwmm    = '0;
      edge_ok = '0;
      cap_hit = '0;
      match   = '0;
      pwm_lvl = '0;
      bufc    = '0;
      bufp    = '0;
      mask    = '0;
      ph      = '0;
      wbit    = '0;
      src     = '0;
      cval    = '0;
      low     = 1'b0;
      // Pins and the external clock are asynchronous to core_clk.
      next_s.s1 = pin_in;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.e1 = ticks.ext_clk;
      next_s.e2 = s.e1;
      next_s.e3 = s.e2;
      next_s.pre  = (s.pre == cca_pkg::PRE_LAST) ? 4'h0 : 4'(s.pre + 4'h1);
      next_s.half = ~s.half;
      unique case (s.counter_mode_register[cca_pkg::B_CPS +: 3])
         cca_pkg::CK_DIV12: tick = (s.pre == cca_pkg::PRE_LAST);
         cca_pkg::CK_DIV2:  tick = s.half;
         cca_pkg::CK_TMR0:  tick = ticks.tmr0_ovf;
         cca_pkg::CK_EXT:   tick = s.e2 & ~s.e3;
         cca_pkg::CK_X16:   tick = ticks.x16_tick;
         cca_pkg::CK_DIV1:  tick = 1'b1;
         cca_pkg::CK_BAUD:  tick = ticks.baud_ovf;
         cca_pkg::CK_MCK:   tick = ticks.mck_tick;
      endcase
      adv = s.run & tick;
      next_s.moved = adv;
      if (adv) begin
         if (s.cnt == cca_pkg::CNT_TOP) begin
            next_s.cnt = s.rld;
         end else begin
            next_s.cnt = 16'(s.cnt + 16'h0001);
         end
      end
      // Mode decode per module: capture, timer compare and duty modes.
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
         capm[i] = (s.mm[i][cca_pkg::M_CAPP] | s.mm[i][cca_pkg::M_CAPN])
            & ~s.mm[i][cca_pkg::M_MAT] & ~s.mm[i][cca_pkg::M_TOG]
            & ~s.mm[i][cca_pkg::M_PWM];
         tmrm[i] = s.mm[i][cca_pkg::M_ECOM] & s.mm[i][cca_pkg::M_MAT]
            & ~s.mm[i][cca_pkg::M_CAPP] & ~s.mm[i][cca_pkg::M_CAPN]
            & ~s.mm[i][cca_pkg::M_PWM];
         pwmm[i] = s.mm[i][cca_pkg::M_ECOM] & s.mm[i][cca_pkg::M_PWM]
            & ~s.mm[i][cca_pkg::M_CAPP] & ~s.mm[i][cca_pkg::M_CAPN]
            & ~s.mm[i][cca_pkg::M_MAT] & ~s.mm[i][cca_pkg::M_TOG];
         edge_ok[i] = (s.mm[i][cca_pkg::M_CAPP] & s.s2[i] & ~s.s3[i])
            | (s.mm[i][cca_pkg::M_CAPN] & ~s.s2[i] & s.s3[i]);
      end
      for (int p = 0; p < 3; p++) begin
         bufc[p] = s.counter_mode_register[cca_pkg::B_BUFFER_PAIR01_ENABLE + p] & capm[2*p] & capm[2*p+1];
         bufp[p] = s.counter_mode_register[cca_pkg::B_BUFFER_PAIR01_ENABLE + p] & pwmm[2*p] & pwmm[2*p+1];
         if (bufc[p]) begin
            // Even pin edges alternate into even, then odd registers.
            if (edge_ok[2*p]) begin
               cap_hit[2*p + int'(s.bsel[p])] = 1'b1;
               next_s.bsel[p] = ~s.bsel[p];
            end
         end else begin
            cap_hit[2*p]   = capm[2*p] & edge_ok[2*p];
            cap_hit[2*p+1] = capm[2*p+1] & edge_ok[2*p+1];
         end
      end
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
         match[i] = tmrm[i] & s.moved
            & (s.cnt == {s.cap_h[i], s.cap_l[i]});
         if (match[i] && s.mm[i][cca_pkg::M_TOG]) begin
            next_s.pin[i] = ~s.pin[i];
         end
         unique case (s.aux[i][cca_pkg::X_RES +: 2])
            2'h0: begin
               mask = 16'h00FF;
               ph   = {8'h00, cca_pkg::PHASE_PT[s.aux[i][5:3]][15:8]};
               wbit = 17'h00100;
            end
            2'h1: begin
               mask = 16'h03FF;
               ph   = {6'h00, cca_pkg::PHASE_PT[s.aux[i][5:3]][15:6]};
               wbit = 17'h00400;
            end
            2'h2: begin
               mask = 16'h0FFF;
               ph   = {4'h0, cca_pkg::PHASE_PT[s.aux[i][5:3]][15:4]};
               wbit = 17'h01000;
            end
            2'h3: begin
               mask = 16'hFFFF;
               ph   = cca_pkg::PHASE_PT[s.aux[i][5:3]];
               wbit = 17'h10000;
            end
         endcase
         if (s.aux[i][cca_pkg::X_RES +: 2] == 2'h0) begin
            src = {8'h00, s.aux[i][cca_pkg::X_EXH], s.cap_h[i]};
         end else begin
            src = ({1'b0, s.cap_h[i], s.cap_l[i]} & {1'b0, mask})
               | (s.aux[i][cca_pkg::X_EXH] ? wbit : 17'h00000);
         end
         // In duty mode reload only at the chosen overflow so duty edits never glitch.
         if (!pwmm[i] || (adv && ((s.cnt & mask) == mask))) begin
            next_s.act[i] = src;
         end
         cval = {1'b0, s.cnt & mask};
         if (ph == 16'h0000) begin
            low = cval < s.act[i];
         end else begin
            low = (17'(cval - {1'b0, ph}) & ({1'b0, mask} | wbit))
               < (17'(s.act[i] - {1'b0, ph}) & ({1'b0, mask} | wbit));
         end
         pwm_lvl[i] = ~low;
      end
      for (int p = 0; p < 3; p++) begin
         if (bufp[p]) begin
            pwm_lvl[2*p+1] = ~pwm_lvl[2*p];
         end
      end
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
         if (pwmm[i]) begin
            next_s.pin[i] = pwm_lvl[i] ^ s.aux[i][cca_pkg::X_INV];
         end
         next_s.oe[i] = pwmm[i] | (tmrm[i] & s.mm[i][cca_pkg::M_TOG]);
      end
      // ------------------------------------------------------------
      // Register writes
      // ------------------------------------------------------------
      if (wr_here) begin
         unique case (req.addr)
            cca_pkg::A_CTRL: begin
               next_s.ovf = req.wdata[cca_pkg::B_OVF];
               next_s.run = req.wdata[cca_pkg::B_RUN];
               next_s.ev  = req.wdata[5:0];
            end
            cca_pkg::A_MODE: next_s.counter_mode_register = req.wdata;
            cca_pkg::A_CNTL: next_s.cnt[7:0] = req.wdata;
            cca_pkg::A_CNTH: next_s.cnt[15:8] = req.wdata;
            cca_pkg::A_RLDL: next_s.rld[7:0] = req.wdata;
            cca_pkg::A_RLDH: next_s.rld[15:8] = req.wdata;
            default: begin
            end
         endcase
         for (int k = 0; k < cca_pkg::NMOD; k++) begin
            if (req.addr == 8'(cca_pkg::A_MM0 + k)) begin
               // Without dead-time the top mode bit is not stored.
               next_s.mm[k] = req.wdata
                  & (HAS_DEADTIME ? 8'hFF : 8'h7F);
            end
            if (req.addr == 8'(cca_pkg::A_CAPL0 + k)) begin
               next_s.cap_l[k] = req.wdata;
            end
            if (req.addr == 8'(cca_pkg::A_CAPH0 + k)) begin
               next_s.cap_h[k] = req.wdata;
            end
            if (req.addr == 8'(cca_pkg::A_AUX0 + k)) begin
               next_s.aux[k] = req.wdata;
            end
         end
      end
      // Hardware sets come last so a set beats a same-cycle clear.
      if (adv && s.cnt == cca_pkg::CNT_TOP) begin
         next_s.ovf = 1'b1;
      end
      for (int i = 0; i < cca_pkg::NMOD; i++) begin
         if (cap_hit[i]) begin
            next_s.cap_l[i] = s.cnt[7:0];
            next_s.cap_h[i] = s.cnt[15:8];
         end
         if (cap_hit[i] || match[i]) begin
            next_s.ev[i] = 1'b1;
         end
      end
      next_s.irq = (next_s.ovf & next_s.counter_mode_register[cca_pkg::B_ECF])
         | (|(next_s.ev & {next_s.mm[5][0], next_s.mm[4][0],
         next_s.mm[3][0], next_s.mm[2][0], next_s.mm[1][0],
         next_s.mm[0][0]}));
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   always_comb begin
      rdata = 8'h00;
      unique case (req.addr)
         cca_pkg::A_CTRL: rdata = {s.ovf, s.run, s.ev};
         cca_pkg::A_MODE: rdata = s.counter_mode_register;
         cca_pkg::A_CNTL: rdata = s.cnt[7:0];
         cca_pkg::A_CNTH: rdata = s.cnt[15:8];
         cca_pkg::A_RLDL: rdata = s.rld[7:0];
         cca_pkg::A_RLDH: rdata = s.rld[15:8];
         default: begin
         end
      endcase
      for (int k = 0; k < cca_pkg::NMOD; k++) begin
         if (req.addr == 8'(cca_pkg::A_MM0 + k)) begin
            rdata = s.mm[k];
         end
         if (req.addr == 8'(cca_pkg::A_CAPL0 + k)) begin
            rdata = s.cap_l[k];
         end
         if (req.addr == 8'(cca_pkg::A_CAPH0 + k)) begin
            rdata = s.cap_h[k];
         end
         if (req.addr == 8'(cca_pkg::A_AUX0 + k)) begin
            rdata = s.aux[k];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   ovf_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
      (adv && s.cnt == 16'hFFFF && !wr_here)
      |=> (s.ovf && s.cnt == $past(s.rld)))
      else $error("Counter wrap did not reload or flag.");
   cnt_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (!s.run && !wr_here) |=> $stable(s.cnt))
      else $error("Counter moved while stopped.");
   irq_gate_a: assert property (@(posedge core_clk) disable iff (srst)
      s.irq == ((s.ovf & s.counter_mode_register[0]) | (|(s.ev & {s.mm[5][0],
      s.mm[4][0], s.mm[3][0], s.mm[2][0], s.mm[1][0], s.mm[0][0]}))))
      else $error("Interrupt does not follow flags and enables.");
   genvar g;
   for (g = 0; g < 6; g++) begin : chk
      cap_copy_a: assert property (@(posedge core_clk) disable iff (srst)
         cap_hit[g] |=> ({s.cap_h[g], s.cap_l[g]} == $past(s.cnt)
         && s.ev[g]))
         else $error("Capture did not copy the counter.");
      any_edge_a: assert property (@(posedge core_clk) disable iff (srst)
         (capm[g] && !bufc[g/2] && s.mm[g][5] && s.mm[g][4]
         && (s.s2[g] != s.s3[g])) |=> s.ev[g])
         else $error("Transition not captured with both edges on.");
      tmr_match_a: assert property (@(posedge core_clk) disable iff (srst)
         (tmrm[g] && s.moved && s.cnt == {s.cap_h[g], s.cap_l[g]})
         |=> s.ev[g])
         else $error("Timer match did not set the event flag.");
      hso_tog_a: assert property (@(posedge core_clk) disable iff (srst)
         (match[g] && s.mm[g][2] && !wr_here)
         |=> (s.pin[g] != $past(s.pin[g])))
         else $error("Output did not toggle on match.");
      ev_stick_a: assert property (@(posedge core_clk) disable iff (srst)
         (s.ev[g] && !wr_here) |=> s.ev[g])
         else $error("Event flag dropped without software.");
      pwm_pin_a: assert property (@(posedge core_clk) disable iff (srst)
         (pwmm[g] && !wr_here)
         |=> (s.pin[g] == ($past(pwm_lvl[g]) ^ $past(s.aux[g][2]))))
         else $error("Duty output level or inversion wrong.");
      reload_8_a: assert property (@(posedge core_clk) disable iff (srst)
         (pwmm[g] && s.aux[g][7:6] == 2'h0 && adv && s.cnt[7:0] == 8'hFF)
         |=> (s.act[g] == {8'h00, $past(s.aux[g][1]), $past(s.cap_h[g])}))
         else $error("Active compare not reloaded at byte wrap.");
   end
endmodule

module counter_array_capture_compare_pwm (
   input  wire logic                core_clk,
   input  wire logic                srst,
   input  wire cca_pkg::sfr_req_t   sfr_req,
   output logic [7:0]               sfr_rdata,
   input  wire cca_pkg::tick_src_t  ticks,
   input  wire logic [1:0][5:0]     module_io_pin_in,
   output logic [1:0][5:0]          module_io_pin_out,
   output logic [1:0][5:0]          module_io_pin_oe,
   output logic [1:0]               irq
);
   cca_pkg::top_state_t t;
   cca_pkg::top_state_t next_t;
   logic [1:0][7:0]     rd;

   // Two independent arrays share only the clock, the reset, the register port and the tick sources.
   for (genvar a = 0; a < 2; a++) begin : arr
      counter_array #(
         .HAS_DEADTIME (a == 0)
      ) u_array (
         .core_clk (core_clk),
         .srst     (srst),
         .req      (sfr_req),
         .sel      (sfr_req.page == 1'(a)),
         .ticks    (ticks),
         .pin_in   (module_io_pin_in[a]),
         .rdata    (rd[a]),
         .pin_out  (module_io_pin_out[a]),
         .pin_oe   (module_io_pin_oe[a]),
         .irq      (irq[a])
      );
   end

   always_comb begin
      next_t = t;
      if (sfr_req.rd) begin
         next_t.rdata = rd[sfr_req.page];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         t <= '0;
      end else begin
         t <= next_t;
      end
   end

   assign sfr_rdata = t.rdata;
endmodule

// file: sim/pin_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pulse source and load on the module pins
// ----------------------------------------------------------------
// A pin that the block drives shows the block's level; an undriven pin
// shows the pulse source, so capture never sees its own output.
module pin_partner (
   input  wire logic [1:0][5:0] src_level,
   input  wire logic [1:0][5:0] drv_level,
   input  wire logic [1:0][5:0] drv_en,
   output logic      [1:0][5:0] pin_level
);
   assign pin_level = (drv_en & drv_level) | (~drv_en & src_level);
endmodule

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic              core_clk = 1'b0;
   logic              srst = 1'b1;
   cca_pkg::sfr_req_t req = '0;
   cca_pkg::tick_src_t ticks = '0;
   logic [7:0]        rdata;
   logic [1:0][5:0]   want = '0;
   logic [1:0][5:0]   pin_lvl;
   logic [1:0][5:0]   pout;
   logic [1:0][5:0]   poe;
   logic [1:0]        irq;
   int                failures = 0;
   int                check_count = 0;
   logic [7:0]        rv;

   always #5 core_clk = ~core_clk;

   counter_array_capture_compare_pwm dut (
      .core_clk(core_clk), .srst(srst), .sfr_req(req), .sfr_rdata(rdata),
      .ticks(ticks), .module_io_pin_in(pin_lvl), .module_io_pin_out(pout),
      .module_io_pin_oe(poe), .irq(irq));
   pin_partner partner (.src_level(want), .drv_level(pout),
      .drv_en(poe), .pin_level(pin_lvl));

   // ----------------------------------------------------------------
   // Bus cycles and comparisons
   // ----------------------------------------------------------------
   task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{addr: a, page: p, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge core_clk);
      req <= '0;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t level %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic p, input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      req <= '{addr: a, page: p, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge core_clk);
      req <= '0;
      #1 rv = rdata;
      chk({8'h00, rv}, {8'h00, e});
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge core_clk);
      srst <= 1'b1;
      want <= '0;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      do_reset();
      for (int p = 0; p < 2; p++) begin
         rdc(p[0], 8'hD8, 8'h00);
         rdc(p[0], 8'hD9, 8'h00);
         rdc(p[0], 8'hCF, 8'h00);
         rdc(p[0], 8'hF2, 8'h00);
      end
      wr(1'b0, 8'hCE, 8'h5A);
      rdc(1'b1, 8'hCE, 8'h00);
      rdc(1'b0, 8'hCE, 8'h5A);
      wr(1'b1, 8'hDA, 8'hFF);
      rdc(1'b1, 8'hDA, 8'h7F);
      wr(1'b0, 8'hA0, 8'h33);
      rdc(1'b0, 8'hA0, 8'h00);
      $display("registers test done");
   endtask
   task automatic t_overflow();
      do_reset();
      wr(1'b1, 8'hCF, 8'hFF);
      wr(1'b1, 8'hE9, 8'hF0);
      wr(1'b1, 8'hF9, 8'hFF);
      wr(1'b1, 8'hD9, 8'h0B);
      wr(1'b1, 8'hD8, 8'h40);
      wait_n(40);
      rdc(1'b1, 8'hD8, 8'hC0);
      chk_bit(irq[1], 1'b1);
      wr(1'b1, 8'hD8, 8'h80);
      // Forty-four steps from FFF0 wrap once to FF00 and stop at FF1C.
      rdc(1'b1, 8'hF9, 8'hFF);
      rdc(1'b1, 8'hE9, 8'h1C);
      wait_n(20);
      rdc(1'b1, 8'hE9, 8'h1C);
      $display("overflow test done");
   endtask
   task automatic t_timer();
      do_reset();
      wr(1'b0, 8'hDB, 8'h49);
      wr(1'b0, 8'hEB, 8'h20);
      wr(1'b0, 8'hD9, 8'h0A);
      wr(1'b0, 8'hD8, 8'h40);
      wait_n(60);
      rdc(1'b0, 8'hD8, 8'h42);
      chk_bit(irq[0], 1'b1);
      wr(1'b0, 8'hD8, 8'h00);
      wait_n(2);
      chk_bit(irq[0], 1'b0);
      $display("timer test done");
   endtask
   task automatic t_toggle();
      do_reset();
      wr(1'b0, 8'hDE, 8'h4C);
      wr(1'b0, 8'hEE, 8'h80);
      wr(1'b0, 8'hFE, 8'hFF);
      wr(1'b0, 8'hCF, 8'hFF);
      wr(1'b0, 8'hF9, 8'hFF);
      wr(1'b0, 8'hD9, 8'h0A);
      wr(1'b0, 8'hD8, 8'h40);
      #1 chk_bit(poe[0][4], 1'b1);
      wait_n(200);
      chk_bit(pin_lvl[0][4], 1'b1);
      wait_n(256);
      chk_bit(pin_lvl[0][4], 1'b0);
      $display("toggle test done");
   endtask
   task automatic t_capture();
      do_reset();
      wr(1'b1, 8'hDC, 8'h21);
      wr(1'b1, 8'hE9, 8'h34);
      wr(1'b1, 8'hF9, 8'h12);
      @(posedge core_clk);
      want[1][2] <= 1'b1;
      wait_n(8);
      rdc(1'b1, 8'hEC, 8'h34);
      rdc(1'b1, 8'hFC, 8'h12);
      rdc(1'b1, 8'hD8, 8'h04);
      chk_bit(irq[1], 1'b1);
      wr(1'b1, 8'hD8, 8'h00);
      wr(1'b1, 8'hE9, 8'h77);
      want[1][2] <= 1'b0;
      wait_n(8);
      rdc(1'b1, 8'hD8, 8'h00);
      wr(1'b1, 8'hDC, 8'h31);
      want[1][2] <= 1'b1;
      wait_n(8);
      rdc(1'b1, 8'hEC, 8'h77);
      $display("capture test done");
   endtask
   task automatic t_pwm();
      logic [7:0]  aux [7] = '{8'h00, 8'h04, 8'h02, 8'h00, 8'h00, 8'h08,
                               8'h20};
      logic [7:0]  cap [7] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'hC0, 8'hC0,
                               8'hAA};
      logic [15:0] exp [7] = '{16'd192, 16'd64, 16'd0, 16'd256, 16'd64,
                               16'h0080, 16'h00AB};
      logic [15:0] hi;
      do_reset();
      wr(1'b0, 8'hDD, 8'h42);
      wr(1'b0, 8'hD9, 8'h0A);
      wr(1'b0, 8'hD8, 8'h40);
      for (int i = 0; i < 7; i++) begin
         wr(1'b0, 8'hF5, aux[i]);
         wr(1'b0, 8'hFD, cap[i]);
         wait_n(300);
         hi = 16'h0000;
         repeat (256) begin
            @(posedge core_clk);
            #1 hi = hi + {15'h0000, pin_lvl[0][3]};
         end
         chk(hi, exp[i]);
      end
      $display("duty test done");
   endtask
   task automatic t_clksel();
      do_reset();
      wr(1'b0, 8'hD9, 8'h06);
      wr(1'b0, 8'hD8, 8'h40);
      repeat (5) begin
         @(posedge core_clk);
         ticks.ext_clk <= 1'b1;
         repeat (4) @(posedge core_clk);
         ticks.ext_clk <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      wait_n(4);
      rdc(1'b0, 8'hE9, 8'h05);
      // Twenty-two edges on the halved clock give exactly eleven steps.
      wr(1'b0, 8'hD9, 8'h02);
      repeat (20) @(posedge core_clk);
      wr(1'b0, 8'hD9, 8'h04);
      repeat (3) begin
         @(posedge core_clk);
         ticks.tmr0_ovf <= 1'b1;
         @(posedge core_clk);
         ticks.tmr0_ovf <= 1'b0;
      end
      wait_n(2);
      rdc(1'b0, 8'hE9, 8'h13);
      rdc(1'b0, 8'hF9, 8'h00);
      $display("clock select test done");
   endtask
   task automatic t_buffer();
      do_reset();
      wr(1'b1, 8'hD9, 8'h10);
      wr(1'b1, 8'hDA, 8'h20);
      wr(1'b1, 8'hDB, 8'h20);
      wr(1'b1, 8'hE9, 8'h11);
      want[1][0] <= 1'b1;
      wait_n(8);
      @(posedge core_clk);
      want[1][0] <= 1'b0;
      wr(1'b1, 8'hE9, 8'h22);
      want[1][0] <= 1'b1;
      wait_n(8);
      rdc(1'b1, 8'hEA, 8'h11);
      rdc(1'b1, 8'hEB, 8'h22);
      $display("buffer test done");
   endtask

   // ----------------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk);
      t_regs();
      t_overflow();
      t_timer();
      t_toggle();
      t_capture();
      t_pwm();
      t_clksel();
      t_buffer();
      tally_and_finish();
   end
   // The tests need about 5000 cycles; a stuck wait ends here.
   initial begin
      #200000;
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule
